// ---- src/irq_enable_request_slice.sv ----
// Interrupt enable/request register slice with request gating
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module irq_enable_request_slice #(
  parameter bit HAS_PIN5 = 1'b1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Source events, one-cycle pulses from same-clock logic
  input wire logic i_watchdog_event,
  input wire logic i_clock_backup_event,
  input wire logic i_low_level_detect_event,
  input wire logic [7:0] i_pin_event,
  // CPU side
  input wire logic i_insn_done,
  input wire logic i_accept,
  input wire logic [7:0] i_accept_sys,
  input wire logic [7:0] i_accept_pin,
  output logic o_nmi_req,
  output logic [7:0] o_sys_req,
  output logic [7:0] o_pin_req,
  // Summary interrupt
  output logic o_irq
);
  localparam logic [7:0] PIN_MASK =
    HAS_PIN5 ? irq_slice_pkg::PIN_FULL_MASK : irq_slice_pkg::PIN_REDUCED_MASK;

  logic [7:0] timebase_pwm_irq_enable_reg;
  logic [7:0] timebase2_irq_enable_reg;
  logic [7:0] system_irq_request_reg;
  logic [7:0] port_pin_irq_request_reg;
  logic [7:0] system_source_enable_reg;
  logic [7:0] port_pin_enable_reg;
  logic master_irq_gate_reg;
  logic [1:0] hold_reg;
  logic [2:0] stat_reg;
  logic [2:0] stat_en_reg;
  logic wr_tb, wr_tb2, wr_sys, wr_pin, wr_sen, wr_pen, wr_mst, wr_clr, wr_ien;
  logic [7:0] sys_set, pin_set, sys_gated, pin_gated;
  localparam int BIT_LLD_IDX = irq_slice_pkg::BIT_LLD;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_tb = i_wr && (i_addr == irq_slice_pkg::ADDR_TB_PWM_EN);
  assign wr_tb2 = i_wr && (i_addr == irq_slice_pkg::ADDR_TB2_EN);
  assign wr_sys = i_wr && (i_addr == irq_slice_pkg::ADDR_SYS_REQ);
  assign wr_pin = i_wr && (i_addr == irq_slice_pkg::ADDR_PIN_REQ);
  assign wr_sen = i_wr && (i_addr == irq_slice_pkg::ADDR_SYS_SRC_EN);
  assign wr_pen = i_wr && (i_addr == irq_slice_pkg::ADDR_PIN_EN);
  assign wr_mst = i_wr && (i_addr == irq_slice_pkg::ADDR_MASTER);
  assign wr_clr = i_wr && (i_addr == irq_slice_pkg::ADDR_IRQ_CLR);
  assign wr_ien = i_wr && (i_addr == irq_slice_pkg::ADDR_IRQ_EN);

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timebase_pwm_irq_enable_reg <= irq_slice_pkg::RESET_VAL;
      timebase2_irq_enable_reg <= irq_slice_pkg::RESET_VAL;
      system_source_enable_reg <= irq_slice_pkg::RESET_VAL;
      port_pin_enable_reg <= irq_slice_pkg::RESET_VAL;
    end else begin
      // Enables survive acceptance; only the master gate drops
      if (wr_tb) begin
        timebase_pwm_irq_enable_reg <= i_wdata & irq_slice_pkg::TB_PWM_EN_MASK;
      end
      if (wr_tb2) begin
        timebase2_irq_enable_reg <= i_wdata & irq_slice_pkg::TB2_EN_MASK;
      end
      if (wr_sen) begin
        system_source_enable_reg <= i_wdata & irq_slice_pkg::SYS_SRC_EN_MASK;
      end
      if (wr_pen) begin
        port_pin_enable_reg <= i_wdata & PIN_MASK;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      master_irq_gate_reg <= 1'b0;
    end else if (i_accept) begin
      master_irq_gate_reg <= 1'b0;
    end else if (wr_mst) begin
      master_irq_gate_reg <= i_wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Request flags: set beats acceptance clear in the same cycle
  // ----------------------------------------------------------------
  always_comb begin
    sys_set = 8'h0000;
    sys_set[0] = i_watchdog_event;
    sys_set[2] = i_clock_backup_event;
    sys_set[BIT_LLD_IDX] = i_low_level_detect_event;
  end
  assign pin_set = i_pin_event & PIN_MASK;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      system_irq_request_reg <= irq_slice_pkg::RESET_VAL;
    end else if (wr_sys) begin
      // Software write stores the value; a same-cycle event still sets
      system_irq_request_reg <= (i_wdata | sys_set) & irq_slice_pkg::SYS_REQ_MASK;
    end else begin
      system_irq_request_reg <= ((system_irq_request_reg & ~(i_accept ? i_accept_sys : 8'h0000))
        | sys_set) & irq_slice_pkg::SYS_REQ_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port_pin_irq_request_reg <= irq_slice_pkg::RESET_VAL;
    end else if (wr_pin) begin
      port_pin_irq_request_reg <= (i_wdata | pin_set) & PIN_MASK;
    end else begin
      port_pin_irq_request_reg <= ((port_pin_irq_request_reg
        & ~(i_accept ? i_accept_pin : 8'h0000)) | pin_set) & PIN_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Presentation delay after a request or pin-enable write
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold_reg <= 2'h0;
    end else if (wr_sys || wr_pin || wr_pen) begin
      hold_reg <= irq_slice_pkg::WRITE_HOLD_INSNS + 2'h1;
    end else if (i_insn_done && hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Gating toward the CPU
  // ----------------------------------------------------------------
  assign sys_gated = (system_irq_request_reg & system_source_enable_reg
    & {8{master_irq_gate_reg}}) | (system_irq_request_reg & irq_slice_pkg::NMI_MASK);
  assign pin_gated = port_pin_irq_request_reg & port_pin_enable_reg
    & {8{master_irq_gate_reg}};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sys_req <= 8'h0000;
      o_pin_req <= 8'h0000;
      o_nmi_req <= 1'b0;
    end else if (hold_reg != 2'h0) begin
      o_sys_req <= 8'h0000;
      o_pin_req <= 8'h0000;
      o_nmi_req <= 1'b0;
    end else begin
      o_sys_req <= sys_gated;
      o_pin_req <= pin_gated;
      o_nmi_req <= |(system_irq_request_reg & irq_slice_pkg::NMI_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Summary status: accept, nmi event, any event
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_clr ? i_wdata[2:0] : 3'h0))
        | {(|sys_set) | (|pin_set), |(sys_set & irq_slice_pkg::NMI_MASK), i_accept};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_en_reg <= 3'h0;
    end else if (wr_ien) begin
      stat_en_reg <= i_wdata[2:0] & irq_slice_pkg::STAT_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_reg & stat_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read port: unmapped and unassigned bits read zero
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        irq_slice_pkg::ADDR_TB_PWM_EN: o_rdata <= timebase_pwm_irq_enable_reg;
        irq_slice_pkg::ADDR_TB2_EN: o_rdata <= timebase2_irq_enable_reg;
        irq_slice_pkg::ADDR_SYS_REQ: o_rdata <= system_irq_request_reg;
        irq_slice_pkg::ADDR_PIN_REQ: o_rdata <= port_pin_irq_request_reg;
        irq_slice_pkg::ADDR_SYS_SRC_EN: o_rdata <= system_source_enable_reg;
        irq_slice_pkg::ADDR_PIN_EN: o_rdata <= port_pin_enable_reg;
        irq_slice_pkg::ADDR_MASTER: o_rdata <= {7'h00, master_irq_gate_reg};
        irq_slice_pkg::ADDR_IRQ_STAT: o_rdata <= {5'h00, stat_reg};
        irq_slice_pkg::ADDR_IRQ_EN: o_rdata <= {5'h00, stat_en_reg};
        default: o_rdata <= 8'h0000;
      endcase
    end else begin
      o_rdata <= 8'h0000;
    end
  end
endmodule

// ---- src/irq_slice_pkg.sv ----
// Constants for the interrupt enable/request register slice
package irq_slice_pkg;
  localparam logic [15:0] ADDR_TB_PWM_EN = 16'hf016;
  localparam logic [15:0] ADDR_TB2_EN = 16'hf017;
  localparam logic [15:0] ADDR_SYS_REQ = 16'hf018;
  localparam logic [15:0] ADDR_PIN_REQ = 16'hf019;
  localparam logic [15:0] ADDR_SYS_SRC_EN = 16'hf010;
  localparam logic [15:0] ADDR_PIN_EN = 16'hf011;
  localparam logic [15:0] ADDR_MASTER = 16'hf01f;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hf020;
  localparam logic [15:0] ADDR_IRQ_CLR = 16'hf021;
  localparam logic [15:0] ADDR_IRQ_EN = 16'hf022;
  localparam logic [7:0] TB_PWM_EN_MASK = 8'h00af;
  localparam logic [7:0] TB2_EN_MASK = 8'h0008;
  localparam logic [7:0] SYS_REQ_MASK = 8'h0045;
  localparam logic [7:0] SYS_SRC_EN_MASK = 8'h0040;
  localparam logic [7:0] PIN_FULL_MASK = 8'h00ff;
  localparam logic [7:0] PIN_REDUCED_MASK = 8'h00df;
  localparam logic [7:0] NMI_MASK = 8'h0005;
  localparam logic [7:0] RESET_VAL = 8'h0000;
  localparam int BIT_LLD = 6;
  localparam int STAT_ACCEPT = 0;
  localparam int STAT_NMI = 1;
  localparam int STAT_EVENT = 2;
  localparam logic [2:0] STAT_MASK = 3'h7;
  // Instructions to let pass before a write-made request is shown
  localparam logic [1:0] WRITE_HOLD_INSNS = 2'h1;
endpackage

// ---- dv/irq_cpu_model.sv ----
// CPU core stand-in: instruction ticks and interrupt acceptance
`timescale 1ns/10ps
module irq_cpu_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests seen from the slice
  input wire logic i_acc_on,
  input wire logic i_nmi,
  input wire logic [7:0] i_sys,
  input wire logic [7:0] i_pin,
  // Instruction and acceptance pulses
  output logic o_done,
  output logic o_acc,
  output logic [7:0] o_acc_sys,
  output logic [7:0] o_acc_pin
);
  logic [1:0] tick_reg;
  always_ff @(posedge i_clk) begin
    tick_reg <= i_rst ? 2'h0 : tick_reg + 2'h1;
    o_done <= !i_rst && tick_reg == 2'h3;
  end
  // Never two acceptances back to back: requests seen here take two cycles to drop
  always_ff @(posedge i_clk) begin
    o_acc <= !i_rst && i_acc_on && !o_acc && (i_nmi || |{i_sys, i_pin});
    o_acc_sys <= i_sys;
    o_acc_pin <= i_pin;
  end
endmodule

// ---- dv/irq_enable_request_slice_assertions.sv ----
// Port-level checks for the interrupt register slice
`timescale 1ns/10ps
module irq_enable_request_slice_assertions (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Events and CPU side
  input wire logic i_watchdog_event,
  input wire logic [7:0] i_pin_event,
  input wire logic i_insn_done,
  input wire logic i_accept,
  input wire logic [7:0] i_accept_pin,
  input wire logic o_nmi_req,
  input wire logic [7:0] o_sys_req,
  input wire logic [7:0] o_pin_req,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reset_clear_a: assert property ($fell(i_rst) |->
    o_rdata == 8'h00 && !o_nmi_req && o_sys_req == 8'h00 && o_pin_req == 8'h00 && !o_irq)
    else $error("outputs not zero after reset");
  read_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data without read strobe");
  sys_layout_a: assert property ((o_sys_req & 8'h00ba) == 8'h00)
    else $error("system request on unassigned bit");
  nmi_pair_a: assert property (o_nmi_req == |(o_sys_req & 8'h05))
    else $error("nmi request disagrees with flags");
  event_sets_a: assert property (i_watchdog_event ##1 (!i_accept && !i_wr)
    ##1 (i_rd && i_addr == irq_slice_pkg::ADDR_SYS_REQ) |=> o_rdata[0])
    else $error("watchdog event did not set flag");
  accept_clears_a: assert property (i_accept && i_accept_pin[7] && !i_pin_event[7]
    && !i_wr ##1 (i_rd && i_addr == irq_slice_pkg::ADDR_PIN_REQ) |=> !o_rdata[7])
    else $error("accepted pin flag not cleared");
  accept_gate_a: assert property (i_accept |-> ##2 (o_pin_req == 8'h00 && !o_sys_req[6]))
    else $error("maskable request after acceptance");
  write_hold_a: assert property (i_wr && (i_addr == irq_slice_pkg::ADDR_PIN_REQ
    || i_addr == irq_slice_pkg::ADDR_PIN_EN || i_addr == irq_slice_pkg::ADDR_SYS_REQ)
    ##1 (!i_insn_done)[*2] |=> o_pin_req == 8'h00 && o_sys_req == 8'h00 && !o_nmi_req)
    else $error("request shown too early after write");
  irq_off_a: assert property (i_wr && i_addr == irq_slice_pkg::ADDR_IRQ_EN && i_wdata == 8'h00
    ##1 !(i_wr && i_addr == irq_slice_pkg::ADDR_IRQ_EN) |=> ##1 !o_irq)
    else $error("interrupt with all enables off");
  cover property (i_accept);
  cover property (o_irq);
  cover property (o_nmi_req && o_pin_req != 8'h00);
endmodule
bind irq_enable_request_slice irq_enable_request_slice_assertions i_chk (.i_clk, .i_rst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_watchdog_event, .i_pin_event, .i_insn_done,
  .i_accept, .i_accept_pin, .o_nmi_req, .o_sys_req, .o_pin_req, .o_irq);

// ---- dv/tb_irq_enable_request_slice.sv ----
// Self-checking bench for the interrupt register slice
`timescale 1ns/10ps
module tb_irq_enable_request_slice;
  logic i_clk, i_rst, i_wr, i_rd, i_watchdog_event, i_clock_backup_event;
  logic i_low_level_detect_event, i_insn_done, i_accept, acc_on, o_nmi_req, o_irq;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_pin_event, i_accept_sys, i_accept_pin, o_sys_req, o_pin_req;
  logic [7:0] msk [4] = '{8'h00af, 8'h0008, 8'h0045, 8'h00ff};
  int num_errors = 0;
  int checks = 0;
  irq_enable_request_slice i_dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_watchdog_event, .i_clock_backup_event, .i_low_level_detect_event, .i_pin_event,
    .i_insn_done, .i_accept, .i_accept_sys, .i_accept_pin, .o_nmi_req, .o_sys_req,
    .o_pin_req, .o_irq);
  irq_cpu_model i_cpu (.i_clk, .i_rst, .i_acc_on(acc_on), .i_nmi(o_nmi_req), .i_sys(o_sys_req),
    .i_pin(o_pin_req), .o_done(i_insn_done), .o_acc(i_accept), .o_acc_sys(i_accept_sys),
    .o_acc_pin(i_accept_pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic pulse(input logic w, input logic c, input logic l, input logic [7:0] p);
    @(posedge i_clk);
    {i_watchdog_event, i_clock_backup_event, i_low_level_detect_event, i_pin_event} <= {w, c, l, p};
    @(posedge i_clk);
    {i_watchdog_event, i_clock_backup_event, i_low_level_detect_event, i_pin_event} <= 11'h000;
  endtask
  task automatic stop_test;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, acc_on} = {3'h4, 16'h0000, 8'h00, 1'b0};
    {i_watchdog_event, i_clock_backup_event, i_low_level_detect_event, i_pin_event} = 11'h000;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(irq_slice_pkg::ADDR_TB_PWM_EN + 16'(i), 8'h00);
      wr_reg(irq_slice_pkg::ADDR_TB_PWM_EN + 16'(i), 8'h00ff);
      rd_reg(irq_slice_pkg::ADDR_TB_PWM_EN + 16'(i), msk[i]);
      wr_reg(irq_slice_pkg::ADDR_TB_PWM_EN + 16'(i), 8'h00);
    end
    rd_reg(16'hf01e, 8'h00);
    pulse(1'b1, 1'b1, 1'b1, 8'h00ff);
    rd_reg(irq_slice_pkg::ADDR_SYS_REQ, 8'h0045);
    rd_reg(irq_slice_pkg::ADDR_PIN_REQ, 8'h00ff);
    repeat (12) @(posedge i_clk);
    chk(o_sys_req, 8'h05);
    chk({7'h00, o_nmi_req}, 8'h01);
    chk(o_pin_req, 8'h00);
    wr_reg(irq_slice_pkg::ADDR_SYS_SRC_EN, 8'h00ff);
    wr_reg(irq_slice_pkg::ADDR_PIN_EN, 8'h0080);
    wr_reg(irq_slice_pkg::ADDR_MASTER, 8'h0001);
    repeat (12) @(posedge i_clk);
    chk(o_sys_req, 8'h0045);
    chk(o_pin_req, 8'h0080);
    wr_reg(irq_slice_pkg::ADDR_IRQ_EN, 8'h0004);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h01);
    wr_reg(irq_slice_pkg::ADDR_IRQ_CLR, 8'h0007);
    wr_reg(irq_slice_pkg::ADDR_IRQ_EN, 8'h0000);
    pulse(1'b1, 1'b0, 1'b0, 8'h00);
    rd_reg(irq_slice_pkg::ADDR_IRQ_STAT, 8'h0006);
    chk({7'h00, o_irq}, 8'h00);
    wr_reg(irq_slice_pkg::ADDR_IRQ_EN, 8'h0002);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h01);
    wr_reg(irq_slice_pkg::ADDR_IRQ_CLR, 8'h0007);
    wr_reg(irq_slice_pkg::ADDR_IRQ_EN, 8'h0000);
    acc_on <= 1'b1;
    for (int n = 0; n < 20 && !i_accept; n++) @(posedge i_clk);
    acc_on <= 1'b0;
    chk({7'h00, i_accept}, 8'h01);
    rd_reg(irq_slice_pkg::ADDR_PIN_REQ, 8'h007f);
    rd_reg(irq_slice_pkg::ADDR_SYS_REQ, 8'h0000);
    rd_reg(irq_slice_pkg::ADDR_PIN_EN, 8'h0080);
    wr_reg(irq_slice_pkg::ADDR_PIN_EN, 8'h00c0);
    repeat (12) @(posedge i_clk);
    chk(o_pin_req, 8'h0000);
    wr_reg(irq_slice_pkg::ADDR_MASTER, 8'h0001);
    repeat (3) @(posedge i_clk);
    chk(o_pin_req, 8'h0040);
    wr_reg(irq_slice_pkg::ADDR_PIN_REQ, 8'h00ff);
    repeat (2) @(posedge i_clk);
    chk(o_pin_req, 8'h0000);
    repeat (12) @(posedge i_clk);
    chk(o_pin_req, 8'h00c0);
    stop_test();
  end
endmodule
